/* logic/cwd_pkg.sv */
package cwd_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] WDC_ADDR      = 8'hC0;
    localparam int         PRE_MSB       = 7;
    localparam int         PRE_LSB       = 4;
    localparam int         RESP_BIT      = 3;
    localparam int         FLAG_BIT      = 2;
    localparam int         RUN_BIT       = 1;
    localparam int         UNLOCK_BIT    = 0;

    // ****************************************
    // reset values and special codes
    // ****************************************
    localparam logic [3:0] PRE_RESET     = 4'h7;
    localparam logic [3:0] PRE_IMM_RESET = 4'h8;
    localparam logic [3:0] PRE_DL_RESET  = 4'h9;
    localparam logic       RESP_RESET    = 1'b0;
    localparam logic       FLAG_RESET    = 1'b0;
    localparam logic       RUN_RESET     = 1'b1;

    // ****************************************
    // timing: crystal rate in Hz, counter width, base shift
    // ****************************************
    localparam int         XTAL_HZ       = 32768;
    localparam int         CNT_W         = 16;
    localparam logic [4:0] BASE_SHIFT    = 5'h09;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        UNLOCK_IDLE = 2'b00,
        UNLOCK_SET  = 2'b01,
        UNLOCK_OPEN = 2'b10
    } cwd_unlock_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cwd_sfr_type;

    typedef struct packed {
        logic [3:0] pre;
        logic       resp;
        logic       flag;
        logic       run;
    } cwd_ctrl_type;

    typedef struct packed {
        cwd_ctrl_type     ctrl;
        cwd_unlock_type   ustate;
        logic [CNT_W-1:0] cnt;
        logic             rst_req;
        logic             dl_req;
        logic             irq;
        logic [7:0]       rdata;
    } cwd_state_type;

    localparam cwd_state_type STATE_RESET = '{
        ctrl:    '{pre: PRE_RESET, resp: RESP_RESET, flag: FLAG_RESET, run: RUN_RESET},
        ustate:  UNLOCK_IDLE,
        cnt:     '0,
        rst_req: 1'b0,
        dl_req:  1'b0,
        irq:     1'b0,
        rdata:   8'h00
    };

    typedef struct packed {
        logic prev;
        logic tick;
    } cwd_tick_state_type;

endpackage

/* logic/cwd_tick.sv */
`timescale 1ns/100ps
module cwd_tick import cwd_pkg::*; (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // crystal level, already synchronous
    input  wire logic level_in,
    // one-cycle enable per crystal rising edge
    output logic      tick
);

    cwd_tick_state_type s_q;
    cwd_tick_state_type s_d;

    always_comb begin
        s_d      = s_q;
        s_d.prev = level_in;
        s_d.tick = level_in & ~s_q.prev;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule

/* logic/cwd_top.sv */
`timescale 1ns/100ps
// Summary of operation
// RULE_01: after reset the watchdog runs with the 2 s timeout and resets on expiry.
// RULE_02: clearing run-enable (bit 1) stops the watchdog; no timeout events. Code 8 or 9 still raises its reset and sets the flag with run-enable clear.
// RULE_03: the counter advances once per crystal period, not per core clock.
// RULE_04: a control write takes effect only right after an unlock step.
// RULE_05: software sets unlock bit 0, then writes next instruction, interrupts masked.
// RULE_06: flash lock bit low forces response select 0 and run-enable 1.
// RULE_07: select field bits 7:4 picks expiry at 2^field times 512 crystal periods.
// RULE_08: codes 0 to 7 give 15.6 ms up to 2 s; reset value selects 2 s.
// RULE_09: code 8 resets at once, code 9 resets into download, 10-15 invalid.
// RULE_10: on expiry, response bit 3 low resets the system, high raises an interrupt.
// RULE_11: timeout flag bit 2 sets on timeout, clears by write 0 or pin reset.
// RULE_12: each write setting run-enable enables and clears the counter.
// RULE_13: the watchdog interrupt is high priority and never masked by global enable.
// RULE_14: the unlock lapses after the instruction following the one that set it.
module cwd_top import cwd_pkg::*; (
    // clock and pin reset
    input  wire logic         CLOCK,
    input  wire logic         RST,
    // system reset from any source, watchdog included
    input  wire logic         SYS_RESET,
    // crystal and flash lock
    input  wire logic         CRYSTAL_INPUT,
    input  wire logic         FLASH_LOCK_BIT,
    // sfr access from the core
    input  wire cwd_sfr_type  SFR_BUS,
    input  wire logic         INSTR_DONE,
    output logic [7:0]        SFR_RDATA,
    // watchdog responses
    output logic              SYS_RESET_REQ,
    output logic              DOWNLOAD_RESET_REQ,
    output logic              WDT_IRQ
);

    cwd_state_type    s_q;
    cwd_state_type    s_d;
    logic             tick;
    logic             wr_hit;
    logic             accept;
    logic             counting;
    logic             expire;
    logic [CNT_W:0]   mask_w;
    logic [CNT_W-1:0] mask;

    // ****************************************
    // crystal edge enable
    // ****************************************
    cwd_tick u_tick (
        .clk      (CLOCK),
        .rst      (RST),
        .level_in (CRYSTAL_INPUT),
        .tick     (tick)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        wr_hit   = SFR_BUS.wr && (SFR_BUS.addr == WDC_ADDR);
        accept   = wr_hit && (s_q.ustate == UNLOCK_OPEN);                    // [RULE_04]
        // codes 8 and above never count: 8 and 9 act at once, the rest are dead
        counting = s_q.ctrl.run && !s_q.ctrl.pre[3];                        // [RULE_02]
        mask_w   = ({{CNT_W{1'b0}}, 1'b1} << (s_q.ctrl.pre[2:0] + BASE_SHIFT)) - 1'b1; // [RULE_07]
        mask     = mask_w[CNT_W-1:0];
        expire   = tick && counting && ((s_q.cnt & mask) == mask);           // [RULE_08]

        s_d         = s_q;
        s_d.rst_req = 1'b0;
        s_d.dl_req  = 1'b0;
        s_d.irq     = 1'b0;

        if (tick && counting) begin
            s_d.cnt = expire ? '0 : s_q.cnt + 1'b1;                          // [RULE_03]
        end
        if (expire) begin
            // no global enable term: the interrupt cannot be masked by the core
            s_d.irq     = s_q.ctrl.resp;                                     // [RULE_10] [RULE_13]
            s_d.rst_req = !s_q.ctrl.resp;                                    // [RULE_01] [RULE_10]
        end
        if (s_q.ctrl.pre == PRE_IMM_RESET) begin
            s_d.rst_req = 1'b1;                                              // [RULE_09]
        end
        if (s_q.ctrl.pre == PRE_DL_RESET) begin
            s_d.dl_req = 1'b1;                                               // [RULE_09]
        end

        // software write path; one accepted write consumes the unlock
        if (accept) begin
            s_d.ctrl.pre  = SFR_BUS.wdata[PRE_MSB:PRE_LSB];
            s_d.ctrl.resp = SFR_BUS.wdata[RESP_BIT];
            s_d.ctrl.run  = SFR_BUS.wdata[RUN_BIT];                          // [RULE_02]
            if (!SFR_BUS.wdata[FLAG_BIT]) begin
                s_d.ctrl.flag = 1'b0;                                        // [RULE_11]
            end
            if (SFR_BUS.wdata[RUN_BIT]) begin
                s_d.cnt = '0;                                                // [RULE_12]
            end
            s_d.ustate = UNLOCK_IDLE;                                        // [RULE_14]
        end else if (wr_hit && SFR_BUS.wdata[UNLOCK_BIT]) begin
            // relies on the core writing in the very next instruction
            s_d.ustate = INSTR_DONE ? UNLOCK_OPEN : UNLOCK_SET;              // [RULE_05]
        end else begin
            case (s_q.ustate)
                UNLOCK_SET: begin
                    if (INSTR_DONE) s_d.ustate = UNLOCK_OPEN;
                end
                UNLOCK_OPEN: begin
                    if (INSTR_DONE) s_d.ustate = UNLOCK_IDLE;                // [RULE_14]
                end
                default: begin
                    s_d.ustate = UNLOCK_IDLE;
                end
            endcase
        end

        // the set wins over a clearing write in the same cycle
        if (expire || s_q.ctrl.pre == PRE_IMM_RESET || s_q.ctrl.pre == PRE_DL_RESET) begin
            s_d.ctrl.flag = 1'b1;                                            // [RULE_11]
        end

        if (SFR_BUS.rd && SFR_BUS.addr == WDC_ADDR) begin
            s_d.rdata = {s_q.ctrl.pre, s_q.ctrl.resp, s_q.ctrl.flag, s_q.ctrl.run,
                         s_q.ustate != UNLOCK_IDLE};
        end else begin
            s_d.rdata = 8'h00;
        end

        // a system reset restores defaults but keeps the flag for software
        if (SYS_RESET) begin
            s_d.ctrl.pre  = PRE_RESET;                                       // [RULE_01] [RULE_08]
            s_d.ctrl.resp = RESP_RESET;
            s_d.ctrl.run  = RUN_RESET;
            s_d.ustate    = UNLOCK_IDLE;
            s_d.cnt       = '0;
            s_d.rst_req   = 1'b0;
            s_d.dl_req    = 1'b0;
            s_d.irq       = 1'b0;
            s_d.rdata     = 8'h00;
        end
        if (!FLASH_LOCK_BIT) begin
            s_d.ctrl.resp = 1'b0;                                            // [RULE_06]
            s_d.ctrl.run  = 1'b1;                                            // [RULE_06]
        end
    end

    // pin reset is the only thing that clears the flag besides software
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s_q <= STATE_RESET;                                              // [RULE_11]
        end else begin
            s_q <= s_d;
        end
    end

    assign SFR_RDATA          = s_q.rdata;
    assign SYS_RESET_REQ      = s_q.rst_req;
    assign DOWNLOAD_RESET_REQ = s_q.dl_req;
    assign WDT_IRQ            = s_q.irq;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    reset_default_a: assert property ($past(RST) |-> s_q.ctrl.pre == 4'h7 && s_q.ctrl.run) // [RULE_01]
        else $error("watchdog not running with 2 s timeout after reset");
    stop_silent_a: assert property (!s_q.ctrl.run && !s_q.ctrl.pre[3] |=> !s_q.irq && !s_q.rst_req) // [RULE_02]
        else $error("stopped watchdog produced an event");
    tick_only_a: assert property (!tick && !accept && !SYS_RESET |=> $stable(s_q.cnt)) // [RULE_03]
        else $error("counter moved without a crystal tick");
    locked_write_a: assert property (wr_hit && s_q.ustate != UNLOCK_OPEN && FLASH_LOCK_BIT && !SYS_RESET // [RULE_04]
                                     |=> $stable(s_q.ctrl.pre) && $stable(s_q.ctrl.run) && $stable(s_q.ctrl.resp))
        else $error("control changed without unlock");
    lock_force_a: assert property (!FLASH_LOCK_BIT |=> s_q.ctrl.run && !s_q.ctrl.resp) // [RULE_06]
        else $error("flash lock did not force the configuration");
    expiry_point_a: assert property (expire && !SYS_RESET |=> s_q.cnt == '0 && (s_q.rst_req || s_q.irq)) // [RULE_07]
        else $error("expiry did not restart counter or respond");
    imm_reset_a: assert property (s_q.ctrl.pre == 4'h8 && !SYS_RESET ##1 !RST |-> s_q.rst_req) // [RULE_09]
        else $error("code 8 did not reset at once");
    response_sel_a: assert property (expire && !s_q.ctrl.resp && !SYS_RESET |=> s_q.rst_req && !s_q.irq) // [RULE_10]
        else $error("reset response not taken");
    flag_keep_a: assert property (s_q.ctrl.flag && SYS_RESET |=> s_q.ctrl.flag) // [RULE_11]
        else $error("timeout flag lost on system reset");
    kick_clear_a: assert property (accept && SFR_BUS.wdata[1] && !SYS_RESET |=> s_q.cnt == '0 && s_q.ctrl.run) // [RULE_12]
        else $error("kick did not clear the counter");
    unlock_lapse_a: assert property (s_q.ustate == UNLOCK_OPEN && INSTR_DONE |=> s_q.ustate != UNLOCK_OPEN) // [RULE_14]
        else $error("unlock outlived the next instruction");

    reset_expiry_c: cover property (expire && !s_q.ctrl.resp);
    irq_expiry_c: cover property (expire && s_q.ctrl.resp);
    accepted_write_c: cover property (accept);
    download_reset_c: cover property (s_q.dl_req);

endmodule

/* verif/cwd_top_test.sv */
`timescale 1ns/100ps
module cwd_top_test import cwd_pkg::*;;
    // ****************************************
    // design hookup
    // ****************************************
    logic        CLOCK          = 1'b0;
    logic        RST            = 1'b1;
    logic        SYS_RESET      = 1'b0;
    logic        CRYSTAL_INPUT  = 1'b0;
    logic        FLASH_LOCK_BIT = 1'b1;
    cwd_sfr_type SFR_BUS        = '0;
    logic        INSTR_DONE     = 1'b0;
    logic [7:0]  SFR_RDATA;
    logic        SYS_RESET_REQ;
    logic        DOWNLOAD_RESET_REQ;
    logic        WDT_IRQ;
    int          miscompares    = 0;
    int          checked        = 0;
    int          n_rst          = 0;
    int          n_irq          = 0;
    int          r0             = 0;
    int          i0             = 0;

    always #20 CLOCK = ~CLOCK;

    cwd_top u_cwd_top (.CLOCK(CLOCK), .RST(RST), .SYS_RESET(SYS_RESET), .CRYSTAL_INPUT(CRYSTAL_INPUT),
        .FLASH_LOCK_BIT(FLASH_LOCK_BIT), .SFR_BUS(SFR_BUS), .INSTR_DONE(INSTR_DONE), .SFR_RDATA(SFR_RDATA),
        .SYS_RESET_REQ(SYS_RESET_REQ), .DOWNLOAD_RESET_REQ(DOWNLOAD_RESET_REQ), .WDT_IRQ(WDT_IRQ));

    // expiry pulses last one cycle, so every edge is looked at
    always @(posedge CLOCK) begin
        if (SYS_RESET_REQ === 1'b1) n_rst <= n_rst + 1;
        if (WDT_IRQ === 1'b1) n_irq <= n_irq + 1;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task stop_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d, input logic done);
        @(posedge CLOCK);
        SFR_BUS    <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        INSTR_DONE <= done;
        @(posedge CLOCK);
        SFR_BUS.wr <= 1'b0;
        INSTR_DONE <= 1'b0;
    endtask

    // unlock, then the write as the very next instruction
    task prog(input logic [7:0] d);
        wr(WDC_ADDR, 8'h01, 1'b1);
        wr(WDC_ADDR, d, 1'b0);
    endtask

    task rd(input logic [7:0] exp, input string name);
        @(posedge CLOCK);
        SFR_BUS.rd   <= 1'b1;
        SFR_BUS.addr <= WDC_ADDR;
        @(posedge CLOCK);
        SFR_BUS.rd   <= 1'b0;
        #1 check(name, SFR_RDATA, exp);
    endtask

    // one crystal period spans five core edges; a fast crystal keeps the run short
    task ticks(input int n);
        repeat (n) begin
            @(posedge CLOCK);
            CRYSTAL_INPUT <= 1'b1;
            repeat (2) @(posedge CLOCK);
            CRYSTAL_INPUT <= 1'b0;
            repeat (2) @(posedge CLOCK);
        end
        repeat (4) @(posedge CLOCK);
    endtask

    task events(input int r, input int i);
        #1;
        check("reset pulses", 8'(n_rst - r0), 8'(r));
        check("irq pulses", 8'(n_irq - i0), 8'(i));
        r0 = n_rst;
        i0 = n_irq;
    endtask

    task pin_reset;
        @(posedge CLOCK);
        RST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_defaults;
        rd(8'h72, "reset value");
        wr(WDC_ADDR, 8'h00, 1'b1);
        rd(8'h72, "write without unlock");
        wr(WDC_ADDR, 8'h01, 1'b1);
        wr(8'h00, 8'h00, 1'b1);
        wr(WDC_ADDR, 8'h08, 1'b1);
        rd(8'h72, "lapsed unlock");
    endtask

    task t_reset_expiry;
        prog(8'h02);
        rd(8'h02, "enabled short");
        ticks(511);
        events(0, 0);
        ticks(1);
        events(1, 0);
        rd(8'h06, "flag after expiry");
        @(posedge CLOCK);
        SYS_RESET <= 1'b1;
        repeat (2) @(posedge CLOCK);
        SYS_RESET <= 1'b0;
        rd(8'h76, "flag kept");
    endtask

    task t_irq_kick;
        prog(8'h1A);
        ticks(600);
        prog(8'h1A);
        ticks(1023);
        events(0, 0);
        ticks(1);
        events(0, 1);
    endtask

    task t_stopped;
        prog(8'h08);
        rd(8'h08, "stopped");
        ticks(600);
        events(0, 0);
        // an invalid select code freezes the counter even while enabled
        prog(8'hA2);
        ticks(8);
        events(0, 0);
        rd(8'hA2, "invalid code held");
    endtask

    task t_locked;
        @(posedge CLOCK);
        FLASH_LOCK_BIT <= 1'b0;
        prog(8'h38);
        rd(8'h32, "locked fields");
        @(posedge CLOCK);
        FLASH_LOCK_BIT <= 1'b1;
    endtask

    task t_instant;
        prog(8'h82);
        repeat (3) @(posedge CLOCK);
        #1 check("instant reset", {7'h00, SYS_RESET_REQ}, 8'h01);
        pin_reset();
        prog(8'h92);
        repeat (3) @(posedge CLOCK);
        #1 check("download reset", {7'h00, DOWNLOAD_RESET_REQ}, 8'h01);
        pin_reset();
        rd(8'h72, "pin reset clears");
    endtask

    // ****************************************
    // sequence and hang guard
    // ****************************************
    initial begin
        repeat (16) @(posedge CLOCK);
        RST <= 1'b0;
        t_defaults();
        t_reset_expiry();
        t_irq_kick();
        t_stopped();
        t_locked();
        t_instant();
        stop_test();
    end

    // the scenarios need about 14000 cycles; allow 80000, almost six times that
    initial begin
        #3200000;
        miscompares++;
        stop_test();
    end
endmodule
